// >>> design/hmcg_consts.svh
// Constants for the halt mode clock gating block
// Behaviour
// R01: Executing the halt instruction enters halt mode, gates the CPU core clock and stops execution.
// R02: Halt entry is accepted whether the CPU runs on the high-speed, internal or subsystem clock.
// R03: Halting from the high-speed clock keeps the 16-bit and 8-bit counters and interval timers running.
// R04: Halting from the internal clock keeps counters and interval timers running, high-speed or not.
// R05: Halting from subsystem clock, software must feed interval timer zero from running counter 50.
// R06: Registers, flags and data memory hold their pre-halt contents throughout halt.
// R07: Port output latches and output buffer states stay unchanged throughout halt.
// R08: With no subsystem clock, the watch timer runs in halt only when fed by the high-speed clock.
// R09: An unmasked interrupt or reset ends halt, restores the CPU clock, and resumes after halt.
`ifndef HMCG_CONSTS_SVH
`define HMCG_CONSTS_SVH
`define HMCG_SRC_HIGH    2'h0
`define HMCG_SRC_INTERN  2'h1
`define HMCG_SRC_SUB     2'h2
`define HMCG_WAKE_CYCLES 1
`define HMCG_PERIPH_ALL  5'h1f
`define HMCG_CFG_RESET   7'h00
`endif

// >>> design/hmcg_halt_ctrl.sv
// Halt mode controller: CPU clock gate, retention hold and peripheral run enables
`timescale 1ns/100ps
`default_nettype none
`include "hmcg_consts.svh"
module hmcg_halt_ctrl (
    input  wire logic                  ref_clk,
    input  wire logic                  reset_n,
    input  wire logic                  halt_exec,
    input  wire logic                  irq_unmasked,
    input  wire hmcg_pkg::hmcg_clkcfg_t clk_cfg,
    output logic                       cpu_clk_en,
    output logic                       cpu_run,
    output logic                       retain_hold,
    output logic                       halted,
    output logic                       resume_pulse,
    output hmcg_pkg::hmcg_periph_t     periph_run
);
    // Controller state and captured clock situation
    hmcg_pkg::hmcg_state_t  state_reg;
    hmcg_pkg::hmcg_state_t  state_next;
    hmcg_pkg::hmcg_clkcfg_t cfg_reg;
    hmcg_pkg::hmcg_clkcfg_t cfg_next;
    hmcg_pkg::hmcg_periph_t periph_reg;
    hmcg_pkg::hmcg_periph_t periph_next;
    hmcg_pkg::hmcg_periph_t periph_halt;
    hmcg_pkg::hmcg_periph_t periph_all;
    logic                   resume_reg;
    logic                   resume_next;

    // All blocks clocked while the CPU runs
    assign periph_all = hmcg_pkg::hmcg_periph_t'(`HMCG_PERIPH_ALL);

    // Entry and exit strobes
    wire in_run  = (state_reg == hmcg_pkg::HMCG_RUN);
    wire in_halt = (state_reg == hmcg_pkg::HMCG_HALT);
    wire enter_w = in_run && halt_exec;                                     // R01 R02
    wire leave_w = in_halt && irq_unmasked;                                 // R09

    // Source decode of the clock situation offered at entry
    wire entry_hi   = (clk_cfg.src == `HMCG_SRC_HIGH);
    wire entry_in   = (clk_cfg.src == `HMCG_SRC_INTERN);
    wire entry_sb   = (clk_cfg.src == `HMCG_SRC_SUB);
    wire entry_fast = entry_hi || entry_in;                                 // R03 R04

    // Interval timer zero on the subsystem clock needs counter 50 feeding it
    wire entry_c50  = entry_sb && clk_cfg.it0_c50 && clk_cfg.c50_run;       // R05
    wire entry_it0  = entry_fast || entry_c50;                              // R03 R04

    // Watch timer: subsystem clock, or high-speed clock still oscillating
    wire entry_whi  = entry_fast && clk_cfg.watch_hi && clk_cfg.high_on;    // R08
    wire entry_wat  = clk_cfg.sub_used || entry_whi;                        // R08

    // Halt-time enables, packed tmr16, tmr8, itmr0, itmr1, watch
    assign periph_halt = {entry_fast, entry_fast, entry_it0, entry_fast, entry_wat}; // R03 R04

    // Source decode of the captured situation, read by the checks
    wire from_hi = (cfg_reg.src == `HMCG_SRC_HIGH);
    wire from_in = (cfg_reg.src == `HMCG_SRC_INTERN);
    wire from_sb = (cfg_reg.src == `HMCG_SRC_SUB);

    // Next state
    always_comb begin
        state_next = state_reg;
        unique case (state_reg)
            hmcg_pkg::HMCG_RUN: begin
                if (enter_w) begin
                    state_next = hmcg_pkg::HMCG_HALT;                       // R01
                end
            end
            hmcg_pkg::HMCG_HALT: begin
                if (leave_w) begin
                    state_next = hmcg_pkg::HMCG_RUN;                        // R09
                end
            end
            default: begin
                state_next = hmcg_pkg::HMCG_RUN;
            end
        endcase
    end

    // Clock situation held from the entry edge to wake-up
    assign cfg_next = enter_w ? clk_cfg : cfg_reg;                          // R02

    // Run enables frozen at entry, all on again at wake-up
    assign periph_next = enter_w ? periph_halt
                       : leave_w ? periph_all
                       : periph_reg;

    // Wake-up strobe for the CPU, one cycle
    assign resume_next = leave_w;                                           // R09

    // State register; reset also ends halt
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            state_reg <= hmcg_pkg::HMCG_RUN;                                // R09
        end else begin
            state_reg <= state_next;
        end
    end

    // Captured clock situation
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            cfg_reg <= hmcg_pkg::hmcg_clkcfg_t'(`HMCG_CFG_RESET);
        end else begin
            cfg_reg <= cfg_next;
        end
    end

    // Run enables register
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            periph_reg <= hmcg_pkg::hmcg_periph_t'(`HMCG_PERIPH_ALL);
        end else begin
            periph_reg <= periph_next;
        end
    end

    // Resume strobe register
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            resume_reg <= 1'b0;
        end else begin
            resume_reg <= resume_next;
        end
    end

    // Clock gate and hold follow the state register
    assign halted       = in_halt;
    assign cpu_clk_en   = !in_halt;                                         // R01
    assign cpu_run      = !in_halt;                                         // R01
    assign retain_hold  = in_halt;                                          // R06 R07
    assign resume_pulse = resume_reg;                                       // R09
    assign periph_run   = periph_reg;                                       // R03 R04 R08

    // Checks, all on the one clock and reset

    // Halt instruction gates the CPU clock on the next cycle
    halt_entry_a: assert property (@(posedge ref_clk) disable iff (!reset_n) // R01
        (!halted && halt_exec) |=> (halted && !cpu_clk_en && !cpu_run))
        else $error("halt not entered");

    // Whatever clock runs the CPU, entry captures its situation
    any_source_a: assert property (@(posedge ref_clk) disable iff (!reset_n) // R02
        (!halted && halt_exec) |=> (halted && (cfg_reg == $past(clk_cfg))))
        else $error("entry situation lost");

    // Subsystem clock entry accepted too
    sub_entry_a: assert property (@(posedge ref_clk) disable iff (!reset_n) // R02
        (!halted && halt_exec && (clk_cfg.src == `HMCG_SRC_SUB)) |=> halted)
        else $error("sub entry refused");

    // High-speed entry keeps counters and interval timers clocked
    hi_timers_a: assert property (@(posedge ref_clk) disable iff (!reset_n) // R03
        (!halted && halt_exec && (clk_cfg.src == `HMCG_SRC_HIGH)) |=>
        (periph_run.tmr16 && periph_run.tmr8 && periph_run.itmr0 && periph_run.itmr1))
        else $error("timers stopped");

    // And keeps them clocked for the whole halt
    hi_hold_a: assert property (@(posedge ref_clk) disable iff (!reset_n) // R03
        (halted && from_hi) |->
        (periph_run.tmr16 && periph_run.tmr8 && periph_run.itmr0 && periph_run.itmr1))
        else $error("timers dropped");

    // Internal-clock entry keeps them clocked, high-speed oscillation or not
    in_timers_a: assert property (@(posedge ref_clk) disable iff (!reset_n) // R04
        (halted && from_in) |->
        (periph_run.tmr16 && periph_run.tmr8 && periph_run.itmr0 && periph_run.itmr1))
        else $error("int timers");

    // Interval timer zero not claimed on subsystem clock without counter 50
    it0_sub_a: assert property (@(posedge ref_clk) disable iff (!reset_n) // R05
        (halted && from_sb && !cfg_reg.it0_c50) |-> !periph_run.itmr0)
        else $error("it0 sub");

    // Interval timer zero clocked when fed by running counter 50
    it0_c50_a: assert property (@(posedge ref_clk) disable iff (!reset_n) // R05
        (halted && from_sb && cfg_reg.it0_c50 && cfg_reg.c50_run) |-> periph_run.itmr0)
        else $error("it0 c50 stopped");

    // Registers and port latches held while halted
    hold_state_a: assert property (@(posedge ref_clk) disable iff (!reset_n) // R06 R07
        halted |-> (retain_hold && !cpu_run))
        else $error("no retention");

    // Nothing captured at entry drifts during halt
    hold_stable_a: assert property (@(posedge ref_clk) disable iff (!reset_n) // R06 R07
        (halted && $past(halted)) |-> ($stable(periph_run) && $stable(cfg_reg)))
        else $error("halt state drifted");

    // Watch timer stopped when not fed by the high-speed clock
    watch_src_a: assert property (@(posedge ref_clk) disable iff (!reset_n) // R08
        (halted && !cfg_reg.sub_used && !cfg_reg.watch_hi) |-> !periph_run.watch)
        else $error("watch ran");

    // Watch timer stopped when high-speed oscillation has stopped
    watch_stop_a: assert property (@(posedge ref_clk) disable iff (!reset_n) // R08
        (halted && !cfg_reg.sub_used && !cfg_reg.high_on) |-> !periph_run.watch)
        else $error("watch ran unfed");

    // Watch timer clocked when fed by running high-speed clock
    watch_hi_a: assert property (@(posedge ref_clk) disable iff (!reset_n) // R08
        (halted && from_hi && !cfg_reg.sub_used && cfg_reg.watch_hi && cfg_reg.high_on)
        |-> periph_run.watch)
        else $error("watch stopped");

    // Unmasked interrupt restores the clock and strobes resume once
    wake_up_a: assert property (@(posedge ref_clk) disable iff (!reset_n) // R09
        (halted && irq_unmasked) |=> (cpu_clk_en && resume_pulse) ##1 !resume_pulse)
        else $error("no wake");

    // Resume strobe only while running, one cycle long
    pulse_once_a: assert property (@(posedge ref_clk) disable iff (!reset_n) // R09
        resume_pulse |-> (!halted && cpu_clk_en) ##1 !resume_pulse)
        else $error("resume strobe stuck");

    // Halt stands until an unmasked interrupt
    halt_stays_a: assert property (@(posedge ref_clk) disable iff (!reset_n) // R01
        (halted && !irq_unmasked) |=> halted)
        else $error("halt left early");

    // Running without the halt instruction stays running, interrupt or not
    run_stays_a: assert property (@(posedge ref_clk) disable iff (!reset_n) // R09
        (!halted && !halt_exec) |=> (!halted && cpu_clk_en))
        else $error("run left early");

    // Every block clocked while the CPU runs
    run_all_on_a: assert property (@(posedge ref_clk) disable iff (!reset_n) // R09
        !halted |-> (periph_run == hmcg_pkg::hmcg_periph_t'(`HMCG_PERIPH_ALL)))
        else $error("block left stopped");

    // Clock enable, run flag and halt flag agree
    clk_mirror_a: assert property (@(posedge ref_clk) disable iff (!reset_n) // R01
        (cpu_clk_en == cpu_run) && (cpu_clk_en == !halted))
        else $error("gate flags disagree");
endmodule : hmcg_halt_ctrl
`default_nettype wire

// >>> design/hmcg_pkg.sv
// Types for the halt mode clock gating block
package hmcg_pkg;
    typedef enum logic [1:0] {
        HMCG_RUN  = 2'b00,
        HMCG_HALT = 2'b01
    } hmcg_state_t;

    // Peripheral run enables
    typedef struct packed {
        logic tmr16;       // 16-bit timer/event counters
        logic tmr8;        // 8-bit timer/event counters
        logic itmr0;       // Interval timer zero
        logic itmr1;       // Interval timer one
        logic watch;       // Watch timer
    } hmcg_periph_t;

    // Clock situation at entry
    typedef struct packed {
        logic [1:0] src;       // CPU clock source
        logic       high_on;   // High-speed oscillation running
        logic       sub_used;  // Subsystem clock in use
        logic       watch_hi;  // Watch timer fed by high-speed clock
        logic       it0_c50;   // Interval timer zero fed by counter_fifty_output
        logic       c50_run;   // Counter 50 running
    } hmcg_clkcfg_t;
endpackage : hmcg_pkg

// >>> verif/halt_mode_clock_gating_test.sv
// Self-checking bench for the halt controller
`timescale 1ns/100ps
`default_nettype none
module halt_mode_clock_gating_test;
    logic ref_clk = 1'b0, reset_n = 1'b0, halt_exec = 1'b0, irq_unmasked = 1'b0;
    logic cpu_clk_en, cpu_run, retain_hold, halted, resume_pulse;
    logic [15:0] n_exec, n0;
    hmcg_pkg::hmcg_clkcfg_t clk_cfg = '0;
    hmcg_pkg::hmcg_periph_t periph_run;
    int n_mismatch = 0, checks_done = 0, cyc = 0;
    always #10 ref_clk = ~ref_clk;
    hmcg_halt_ctrl dut_u (.ref_clk(ref_clk), .reset_n(reset_n), .halt_exec(halt_exec),
        .irq_unmasked(irq_unmasked), .clk_cfg(clk_cfg), .cpu_clk_en(cpu_clk_en),
        .cpu_run(cpu_run), .retain_hold(retain_hold), .halted(halted),
        .resume_pulse(resume_pulse), .periph_run(periph_run));
    hmcg_cpu_model cpu_u (.ref_clk(ref_clk), .cpu_clk_en(cpu_clk_en), .n_exec(n_exec));
    // Compare and count
    task chk(input logic [7:0] got, input logic [7:0] exp);
        checks_done++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    // Halt, check, retry halt, then wake by interrupt
    task halt_case(input logic [6:0] cfg, input logic [4:0] exp, input logic [4:0] m);
        @(posedge ref_clk) clk_cfg <= hmcg_pkg::hmcg_clkcfg_t'(cfg);
        halt_exec <= 1'b1;
        @(posedge ref_clk) halt_exec <= 1'b0;
        @(posedge ref_clk) halt_exec <= 1'b1;
        #1 n0 = n_exec;
        chk({4'h0, halted, cpu_clk_en, cpu_run, retain_hold}, 8'h09);
        chk({3'h0, periph_run & m}, {3'h0, exp});
        @(posedge ref_clk) halt_exec <= 1'b0;
        repeat (3) @(posedge ref_clk);
        #1 chk(n_exec[7:0], n0[7:0]);
        chk({7'h00, halted}, 8'h01);
        @(posedge ref_clk) irq_unmasked <= 1'b1;
        @(posedge ref_clk) irq_unmasked <= 1'b0;
        #1 chk({resume_pulse, halted, cpu_clk_en, periph_run}, 8'hbf);
        @(posedge ref_clk);
        #1 chk({7'h00, resume_pulse}, 8'h00);
        chk(n_exec[7:0], n0[7:0] + 8'h01);
        $display("halt case %h done", cfg);
    endtask : halt_case
    // Reset in mid-halt ends halt
    task reset_case;
        @(posedge ref_clk) halt_exec <= 1'b1;
        @(posedge ref_clk) halt_exec <= 1'b0;
        #1 chk({7'h00, halted}, 8'h01);
        @(posedge ref_clk) reset_n <= 1'b0;
        @(posedge ref_clk) reset_n <= 1'b1;
        #1 chk({resume_pulse, halted, cpu_clk_en, periph_run}, 8'h3f);
        $display("reset case done");
    endtask : reset_case
    // Verdict
    task results;
        $display("checks %0d mismatches %0d", checks_done, n_mismatch);
        if (n_mismatch == 0 && checks_done > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask : results
    always @(posedge ref_clk) begin
        cyc <= cyc + 1;
        if (cyc == 2000) begin
            n_mismatch++;
            $display("[ERR] t=%0t timeout cyc=%h limit=%h", $time, cyc, 2000);
            results();
        end
    end
    initial begin
        repeat (10) @(posedge ref_clk);
        reset_n <= 1'b1;
        halt_case(7'h10, 5'h1e, 5'h1f);
        halt_case(7'h14, 5'h1f, 5'h1f);
        halt_case(7'h28, 5'h1f, 5'h1f);
        halt_case(7'h24, 5'h1e, 5'h1f);
        halt_case(7'h34, 5'h1f, 5'h1f);
        halt_case(7'h4b, 5'h05, 5'h05);
        halt_case(7'h4a, 5'h01, 5'h05);
        halt_case(7'h60, 5'h00, 5'h1f);
        reset_case();
        results();
    end
endmodule : halt_mode_clock_gating_test
`default_nettype wire

// >>> verif/hmcg_cpu_model.sv
// CPU core model counting cycles it executes
`timescale 1ns/100ps
`default_nettype none
module hmcg_cpu_model (
    input  wire logic        ref_clk,
    input  wire logic        cpu_clk_en,
    output logic      [15:0] n_exec
);
    logic [15:0] count_reg = 16'h0000;
    // Executes only while its clock is supplied
    always @(posedge ref_clk) if (cpu_clk_en) count_reg <= count_reg + 16'h0001;
    assign n_exec = count_reg;
endmodule : hmcg_cpu_model
`default_nettype wire
